// ---- byte_mux.v ----
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"
// Read-data selector over the seven register bytes
module byte_mux (
  input  wire [2:0] addr_i, // Register offset
  input  wire [7:0] c0_i,   // Control zero
  input  wire [7:0] c1_i,   // Control one
  input  wire [9:0] cnt_i,  // Counter
  input  wire [9:0] cmpa_i, // Compare A value
  input  wire [1:0] fl_i,   // Flags
  output reg  [7:0] dat_o   // Selected byte
);
  // Unused high bits read zero
  always @*
  begin
    case (addr_i)
      `CT_OFF_CTRL0:   dat_o = c0_i;
      `CT_OFF_CTRL1:   dat_o = c1_i;
      `CT_OFF_CNT_LO:  dat_o = cnt_i[7:0];
      `CT_OFF_CNT_HI:  dat_o = {6'h00, cnt_i[9:8]};
      `CT_OFF_CMPA_LO: dat_o = cmpa_i[7:0];
      `CT_OFF_CMPA_HI: dat_o = {6'h00, cmpa_i[9:8]};
      `CT_OFF_FLAGS:   dat_o = {6'h00, fl_i};
      default:         dat_o = 8'h00;
    endcase
  end
endmodule // byte_mux
`default_nettype wire

// ---- compact_timer.v ----
// Function
// [RQ1] Compare mode: initial-level bit sets pin level before any match.
// [RQ2] PWM mode: initial-level bit picks active polarity, 1 active high.
// [RQ3] Invert bit flips pin; neither bit matters in timer mode.
// [RQ4] Swap bit 0: code is period, compare is duty; 1 exchanges.
// [RQ5] Clear-select 1 clears on A match; 0 on P match or overflow.
// [RQ6] Overflow clearing only when period code is all zero.
// [RQ7] PWM ignores clear-select; period register's match clears counter.
// [RQ8] Counter read as two bytes, high byte upper six bits zero.
// [RQ9] Compare A held as two read/write bytes, reset zero.
// [RQ10] Mode 00 compare, 10 PWM, 11 timer/counter.
// [RQ11] Compare, clear-select 0: A flag on A match, P on P.
// [RQ12] Compare, clear-select 1: only A flag, never P flag.
// [RQ13] A-clear with A value zero overflows at 3FF, no A flag.
// [RQ14] Compare mode pin changes only on flagged A match.
// [RQ15] Output field drives low, high, toggle on A match; 00 none.
// [RQ16] Counter-on rising loads pin with initial level.
// [RQ17] Timer mode like compare mode, pin not driven.
// [RQ18] PWM raises A and P flags; period match clears counter.
// [RQ19] Swap 0: period 128 times code, 000 is 1024; duty compare.
// [RQ20] Duty at or above period gives full active output.
// [RQ21] Swap 1: period is compare value; duty 128 times code.
// [RQ22] PWM logic keeps running while pin forced by 00 or 01.
// [RQ23] PWM field 00 inactive, 01 active, 10 waveform, 11 undefined.
// [RQ24] Compare field 01 low, 10 high, 11 toggle on A match.
// [RQ25] Counter-on rise zeroes counter; fall stops and keeps count.
// [RQ26] 10-bit up-counter; code versus bits 9:7, compare versus all.
// [RQ27] Match seen on the tick counter equals value; flag before clear.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"
module compact_timer #(
  parameter TICK_DIV = `CT_TICK_DIV
) (
  input  wire       mclk_i,     // 20 MHz system clock
  input  wire       arst_n_i,   // Async reset, active low
  input  wire [2:0] addr_i,     // Register offset
  input  wire [7:0] wdata_i,    // Write data
  input  wire       wr_i,       // Write strobe
  input  wire       rd_i,       // Read strobe
  output reg  [7:0] rdata_o,    // Read data, cycle after strobe
  output reg        pin_o,      // Timer output pin level
  output reg        pin_oe_o,   // Pin driven by timer
  output reg        flag_a_o,   // Compare A flag
  output reg        flag_p_o    // Compare P flag
);
  reg  [7:0] c0_reg;
  reg  [7:0] c1_reg;
  reg  [9:0] cnt_reg;
  reg  [9:0] cnt_next;
  reg  [9:0] cmpa_reg;
  reg  [7:0] cmpa_buf_reg;
  reg        on_d_reg;
  reg        lvl_reg;
  reg        lvl_next;
  reg        pwm_act_reg;
  reg        pwm_act_next;
  reg        set_a;
  reg        set_p;
  wire [7:0] rd_byte;
  wire       tick;
  wire       wr_c0;
  wire       wr_c1;
  wire       wr_alo;
  wire       wr_ahi;
  wire       wr_fl;
  wire       clr_a;
  wire       clr_p;
  reg        a_pwm;
  reg        p_pwm;
  reg        pin_next;

  wire       ton      = c0_reg[`CT_C0_ON];
  wire [2:0] rp       = c0_reg[`CT_C0_RP_LSB +: 3];
  wire       cclr     = c1_reg[`CT_C1_CCLR];
  wire       dpx      = c1_reg[`CT_C1_DPX];
  wire       pol      = c1_reg[`CT_C1_POL];
  wire       oc       = c1_reg[`CT_C1_OC];
  wire [1:0] iof      = c1_reg[`CT_C1_IO_LSB +: 2];
  wire [1:0] mode     = c1_reg[`CT_C1_MODE_LSB +: 2];
  wire       on_rise  = ton & ~on_d_reg;
  wire       is_pwm   = (mode == `CT_MODE_PWM);
  wire       is_tmr   = (mode == `CT_MODE_TMR);

  // Comparators: P sees counter top three bits, A sees all bits
  wire       p_hit    = (cnt_reg[9:7] == rp) & (cnt_reg[6:0] == 7'h00); // RQ26
  wire       a_hit    = (cnt_reg == cmpa_reg);                          // RQ26
  wire       at_max   = (cnt_reg == 10'h3FF);

  // Period and duty in timer clocks, code 000 meaning 1024
  wire [10:0] code_len = (rp == 3'b000) ? 11'h400 : {1'b0, rp, 7'h00}; // RQ19
  wire [10:0] per_len  = dpx ? {1'b0, cmpa_reg} : code_len;         // RQ4
  wire [10:0] duty_len = dpx ? code_len : {1'b0, cmpa_reg};         // RQ21
  wire [10:0] cnt_w    = {1'b0, cnt_reg};

  tick_divider #(
    .DIV      (TICK_DIV)
  ) u_div (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .run_i    (ton),
    .tick_o   (tick)
  );

  byte_mux u_mux (
    .addr_i   (addr_i),
    .c0_i     (c0_reg),
    .c1_i     (c1_reg),
    .cnt_i    (cnt_reg),
    .cmpa_i   (cmpa_reg),
    .fl_i     ({flag_p_o, flag_a_o}),
    .dat_o    (rd_byte)
  );

  // PWM matches: the period comparator fires on its last count, since
  // the counter wraps before it could ever equal the period itself;
  // a zero code as duty stands for 1024 and so never matches
  always @*
  begin
    if (dpx)
    begin
      a_pwm = (cnt_w + 11'h001 == per_len);                   // RQ21
      p_pwm = p_hit & (rp != 3'b000);
    end
    else
    begin
      a_pwm = a_hit;
      p_pwm = (cnt_w + 11'h001 == per_len);                   // RQ19
    end
  end

  // Counter step, clear choice and match flags
  always @*
  begin
    cnt_next = cnt_reg + 10'h001;
    set_a    = 1'b0;
    set_p    = 1'b0;
    if (is_pwm)
    begin
      // Period register match clears; clear-select ignored
      set_a = a_pwm;                                          // RQ18
      set_p = p_pwm;                                          // RQ18
      if (cnt_w + 11'h001 >= per_len)                         // RQ7
        cnt_next = 10'h000;
    end
    else if (cclr)
    begin
      // A-match clearing; zero A value just wraps at 3FF
      if (cmpa_reg == 10'h000)
        set_a = 1'b0;                                         // RQ13
      else
        set_a = a_hit;                                        // RQ12
      if (a_hit && cmpa_reg != 10'h000)                       // RQ5
        cnt_next = 10'h000;
    end
    else
    begin
      set_a = a_hit;                                          // RQ11
      set_p = p_hit & (rp != 3'b000);                         // RQ11
      if (set_p)                                              // RQ5
        cnt_next = 10'h000;
      else if (at_max && rp == 3'b000)                        // RQ6
        cnt_next = 10'h000;
    end
  end

  // Compare-mode output level on a flagged A match
  always @*
  begin
    lvl_next = lvl_reg;
    if (on_rise)
      lvl_next = oc;                                          // RQ16 RQ1
    else if (tick && set_a)                                   // RQ14
    begin
      case (iof)                                              // RQ15 RQ24
        2'b01:   lvl_next = 1'b0;
        2'b10:   lvl_next = 1'b1;
        2'b11:   lvl_next = ~lvl_reg;
        default: lvl_next = lvl_reg;
      endcase
    end
  end

  // PWM active phase: active while count below duty
  always @*
  begin
    pwm_act_next = pwm_act_reg;
    if (on_rise)
      pwm_act_next = 1'b0;
    else if (tick)
    begin
      if (duty_len >= per_len)                                // RQ20
        pwm_act_next = 1'b1;
      else
        pwm_act_next = ({1'b0, cnt_next} < duty_len);         // RQ19 RQ21
    end
  end

  // Write decodes; offset 7 and the counter bytes take no writes,
  // so software can never move the count except by a counter-on rise
  assign wr_c0  = wr_i && (addr_i == `CT_OFF_CTRL0);
  assign wr_c1  = wr_i && (addr_i == `CT_OFF_CTRL1);
  assign wr_alo = wr_i && (addr_i == `CT_OFF_CMPA_LO);
  assign wr_ahi = wr_i && (addr_i == `CT_OFF_CMPA_HI);
  assign wr_fl  = wr_i && (addr_i == `CT_OFF_FLAGS);
  assign clr_a  = wr_fl && wdata_i[`CT_FL_A];
  assign clr_p  = wr_fl && wdata_i[`CT_FL_P];

  // Control zero: period code and counter on
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      c0_reg <= `CT_RST_BYTE;
    else if (wr_c0)
      c0_reg <= wdata_i;
  end

  // Control one; mode and output changes belong with the counter off,
  // a change while running takes effect at once and may glitch the pin
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      c1_reg <= `CT_RST_BYTE;
    else if (wr_c1)
      c1_reg <= wdata_i;                                      // RQ10
  end

  // Compare A: low byte waits in a buffer until the high byte lands,
  // so the comparator never sees half of a new value
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmpa_buf_reg <= `CT_RST_BYTE;
      cmpa_reg     <= 10'h000;                                // RQ9
    end
    else
    begin
      if (wr_alo)
        cmpa_buf_reg <= wdata_i;
      if (wr_ahi)
        cmpa_reg <= {wdata_i[1:0], cmpa_buf_reg};             // RQ9
    end
  end

  // Counter-on history; resets to off so reset gives no false rise
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      on_d_reg <= 1'b0;
    else
      on_d_reg <= ton;
  end

  // Counter: zeroed by counter-on rise, one step a tick, held when off
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_reg <= 10'h000;
    else if (on_rise)
      cnt_reg <= 10'h000;                                     // RQ25
    else if (tick)
      cnt_reg <= cnt_next;                                    // RQ26 RQ22
  end

  // Sticky flags; set beats a same-cycle clear so no match is lost
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_a_o <= 1'b0;
      flag_p_o <= 1'b0;
    end
    else
    begin
      flag_a_o <= (tick & set_a) | (flag_a_o & ~clr_a);       // RQ27
      flag_p_o <= (tick & set_p) | (flag_p_o & ~clr_p);       // RQ27
    end
  end

  // Compare-mode level and PWM phase
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lvl_reg     <= 1'b0;
      pwm_act_reg <= 1'b0;
    end
    else
    begin
      lvl_reg     <= lvl_next;
      pwm_act_reg <= pwm_act_next;
    end
  end

  // Pin level ahead of its flop; mode 01 is undefined, acts as compare
  always @*
  begin
    pin_next = 1'b0;
    case (mode)
      `CT_MODE_PWM:
      begin
        case (iof)                                            // RQ23
          2'b00:   pin_next = ~oc ^ pol;
          2'b01:   pin_next = oc ^ pol;
          2'b10:   pin_next = (pwm_act_next ? oc : ~oc) ^ pol; // RQ2 RQ3
          default: pin_next = ~oc ^ pol;
        endcase
      end
      `CT_MODE_TMR:
        pin_next = 1'b0;                                      // RQ3 RQ17
      default:
        pin_next = lvl_next ^ pol;                            // RQ1 RQ3
    endcase
  end

  // Read data only in the cycle after the strobe, zero otherwise
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? rd_byte : 8'h00;                      // RQ8
  end

  // Pin and enable straight from flops so the pad sees no decode glitch
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end
    else
    begin
      pin_o    <= pin_next;
      pin_oe_o <= ~is_tmr;                                    // RQ17
    end
  end
endmodule // compact_timer
`default_nettype wire

// ---- compact_timer_consts.vh ----
`ifndef COMPACT_TIMER_CONSTS_VH
`define COMPACT_TIMER_CONSTS_VH
// Register offsets on the plain register port
`define CT_OFF_CTRL0      3'h0
`define CT_OFF_CTRL1      3'h1
`define CT_OFF_CNT_LO     3'h2
`define CT_OFF_CNT_HI     3'h3
`define CT_OFF_CMPA_LO    3'h4
`define CT_OFF_CMPA_HI    3'h5
`define CT_OFF_FLAGS      3'h6
// Control zero fields (period code, counter on)
`define CT_C0_RP_LSB      0
`define CT_C0_ON          3
// Control one fields
`define CT_C1_CCLR        0
`define CT_C1_DPX         1
`define CT_C1_POL         2
`define CT_C1_OC          3
`define CT_C1_IO_LSB      4
`define CT_C1_MODE_LSB    6
// Flag register fields
`define CT_FL_A           0
`define CT_FL_P           1
// Mode codes
`define CT_MODE_CMP       2'b00
`define CT_MODE_PWM       2'b10
`define CT_MODE_TMR       2'b11
// Reset values
`define CT_RST_BYTE       8'h00
// Timer clock divider default (timer tick every N system clocks)
`define CT_TICK_DIV       4
`endif

// ---- compact_timer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the timer
module compact_timer_properties (
  input wire logic       mclk_i,   // Clock
  input wire logic       arst_n_i, // Reset, active low
  input wire logic [2:0] addr_i,   // Offset
  input wire logic [7:0] wdata_i,  // Write data
  input wire logic       wr_i,     // Write strobe
  input wire logic       rd_i,     // Read strobe
  input wire logic [7:0] rdata_o,  // Read data
  input wire logic       pin_o,    // Pin level
  input wire logic       pin_oe_o, // Pin enable
  input wire logic       flag_a_o, // Flag A
  input wire logic       flag_p_o  // Flag P
);
  logic [7:0] c1_reg;
  logic [7:0] c1_d_reg;
  logic       on_reg;
  logic       on_d_reg;
  // Shadow of control writes; delayed copy marks a settled setting
  always_ff @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      c1_reg   <= 8'h00;
      c1_d_reg <= 8'h00;
      on_reg   <= 1'b0;
      on_d_reg <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == 3'h1)
        c1_reg <= wdata_i;
      if (wr_i && addr_i == 3'h0)
        on_reg <= wdata_i[3];
      c1_d_reg <= c1_reg;
      on_d_reg <= on_reg;
    end
  // Settled setting, timer running
  wire set_w = (c1_reg == c1_d_reg) && on_reg && on_d_reg;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence rd_s(logic [2:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence clr_s(int b);
    wr_i && addr_i == 3'h6 && wdata_i[b];
  endsequence
  count_high_pad_a: assert property (
    rd_s(3'h3) |=> rdata_o[7:2] == 6'h00) else $error("counter high pad");
  cmpa_high_pad_a: assert property (
    rd_s(3'h5) |=> rdata_o[7:2] == 6'h00) else $error("compare high pad");
  flag_a_sticky_a: assert property (
    flag_a_o && !clr_s(0) |=> flag_a_o) else $error("flag A dropped");
  flag_p_sticky_a: assert property (
    flag_p_o && !clr_s(1) |=> flag_p_o) else $error("flag P dropped");
  no_p_flag_a: assert property (
    c1_reg == c1_d_reg && c1_reg[7] == c1_reg[6] && c1_reg[0]
    |-> !$rose(flag_p_o)) else $error("flag P under A clear");
  timer_pin_idle_a: assert property (
    c1_reg == c1_d_reg && c1_reg[7:6] == 2'b11 |-> !pin_oe_o)
    else $error("pin driven in timer mode");
  pwm_force_a: assert property (
    set_w && c1_reg[7:4] == 4'h8 || set_w && c1_reg[7:4] == 4'h9
    |-> pin_oe_o && pin_o == (c1_reg[3] ^ c1_reg[2] ^ !c1_reg[4]))
    else $error("forced level wrong");
  start_level_a: assert property (
    on_reg && !on_d_reg && c1_reg[7:6] == 2'b00
    |-> ##[1:2] pin_o == (c1_reg[3] ^ c1_reg[2]))
    else $error("start level wrong");
endmodule // compact_timer_properties
bind compact_timer compact_timer_properties compact_timer_properties_inst (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .flag_a_o(flag_a_o),
  .flag_p_o(flag_p_o));
`default_nettype wire

// ---- compact_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module compact_timer_tb;
  logic       mclk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       pin_o;
  logic       pin_oe_o;
  logic       flag_a_o;
  logic       flag_p_o;
  logic       pad_w;
  logic [7:0] rd_v;
  logic [7:0] rd2_v;
  logic [9:0] val_v;
  integer     n_fail = 0;
  integer     cmp_count = 0;
  integer     seed = 32'hdcbe;
  integer     cycles = 0;
  integer     i;
  integer     k;
  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;
  compact_timer #(.TICK_DIV(4)) compact_timer_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .flag_a_o(flag_a_o),
    .flag_p_o(flag_p_o));
  pin_load pin_load_inst (.pin_i(pin_o), .oe_i(pin_oe_o), .pad_o(pad_w));
  task automatic final_report;
    $display("cmp_count=%0d n_fail=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One strobe cycle, then one idle cycle so settings land first
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    // Data stands only until the next edge; take it mid-cycle
    @(negedge mclk_i);
    d = rdata_o;
    @(posedge mclk_i);
  endtask
  // Low byte is buffered until the high byte commits
  task automatic seta(input logic [9:0] v);
    wr_reg(3'h4, v[7:0]);
    wr_reg(3'h5, {6'h00, v[9:8]});
  endtask
  // Stop, clear flags, configure, then start
  task automatic start(input logic [7:0] c1, input logic [2:0] code);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h6, 8'h03);
    wr_reg(3'h1, c1);
    wr_reg(3'h0, {5'h01, code});
  endtask
  task automatic wait_f(input logic p, input integer lim);
    k = 0;
    while ((p ? flag_p_o : flag_a_o) !== 1'b1 && k < lim)
    begin
      @(posedge mclk_i);
      k++;
    end
  endtask
  // Clock cycles the pad spends high
  task automatic measure(input integer n, output integer hi);
    hi = 0;
    repeat (n)
    begin
      @(negedge mclk_i);
      hi += pad_w;
    end
    @(posedge mclk_i);
  endtask
  // Hang guard, well above the expected run
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    // Every offset resets to zero, unmapped one too
    for (i = 0; i < 8; i++)
    begin
      rd_reg(i[2:0], rd_v);
      check(rd_v, 10'h000);
    end
    // Random compare values read back in two bytes
    repeat (4)
    begin
      val_v = $random(seed);
      seta(val_v);
      rd_reg(3'h4, rd_v);
      check(rd_v, val_v[7:0]);
      rd_reg(3'h5, rd_v);
      check(rd_v, val_v[9:8]);
    end
    wr_reg(3'h7, 8'hff);
    rd_reg(3'h7, rd_v);
    check(rd_v, 10'h000);
    // Compare mode, P clear at 128, toggle on A match
    seta(10'h032);
    start(8'h30, 3'h1);
    @(negedge mclk_i);
    check(pin_o, 10'h000);
    wait_f(1'b0, 400);
    repeat (2) @(posedge mclk_i);
    check(pin_o, 10'h001);
    wait_f(1'b1, 800);
    check(flag_p_o, 10'h001);
    rd_reg(3'h2, rd_v);
    check(rd_v < 8'h10, 10'h001);
    // A clear at 20, no P flag, no pin change with field 00
    seta(10'h014);
    start(8'h01, 3'h1);
    repeat (700) @(posedge mclk_i);
    check(flag_a_o, 10'h001);
    check(flag_p_o, 10'h000);
    check(pin_o, 10'h000);
    rd_reg(3'h2, rd_v);
    check(rd_v <= 8'h14, 10'h001);
    // Stop keeps the count
    wr_reg(3'h0, 8'h01);
    rd_reg(3'h2, rd_v);
    repeat (40) @(posedge mclk_i);
    rd_reg(3'h2, rd2_v);
    check(rd2_v, rd_v);
    // Timer mode releases the pin to the pull-down
    start(8'hc0, 3'h1);
    repeat (40) @(posedge mclk_i);
    check(pad_w, 10'h000);
    check(pin_oe_o, 10'h000);
    // PWM, code period 128 ticks, random duty, both polarities
    for (i = 0; i < 2; i++)
    begin
      val_v = $random(seed) & 10'h07f;
      seta(val_v);
      start(i ? 8'hac : 8'ha8, 3'h1);
      repeat (8) @(posedge mclk_i);
      measure(512, k);
      check(10'(k), i ? 10'(512 - val_v * 4) : 10'(val_v * 4));
      check({flag_a_o, flag_p_o}, 10'h003);
    end
    // Swapped roles: period 64, duty 128 gives full active
    seta(10'h040);
    start(8'haa, 3'h1);
    repeat (8) @(posedge mclk_i);
    measure(256, k);
    check(10'(k), 10'h100);
    // Forced active level while the counter runs
    start(8'h98, 3'h1);
    measure(64, k);
    check(10'(k), 10'h040);
    final_report();
  end
endmodule // compact_timer_tb
`default_nettype wire

// ---- pin_load.sv ----
`timescale 1ns/1ps
`default_nettype none
// Board load on the timer pin, weak pull-down when released
module pin_load (
  input  wire logic pin_i, // Level from timer
  input  wire logic oe_i,  // Timer drives the pin
  output logic      pad_o  // Level seen on the board
);
  // Pull-down wins once the timer lets go of the pin
  assign pad_o = oe_i ? pin_i : 1'b0;
endmodule // pin_load
`default_nettype wire

// ---- tick_divider.v ----
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock into one-cycle timer tick pulses
module tick_divider #(
  parameter DIV = 4
) (
  input  wire mclk_i,   // System clock
  input  wire arst_n_i, // Async reset, active low
  input  wire run_i,    // Counting enabled
  output reg  tick_o    // One-cycle tick
);
  reg [15:0] cnt_reg;

  // Free divider restarted while stopped
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end
    else if (cnt_reg == DIV[15:0] - 16'h0001)
    begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o  <= 1'b0;
    end
  end
endmodule // tick_divider
`default_nettype wire
